// ---- verilog/lbc_consts.svh ----
// Constants of the local bus command controller: delays and reset values.
// Assumes inclusion by bare name from the controller module and the testbench.
`ifndef LBC_CONSTS_SVH
`define LBC_CONSTS_SVH

// -----------------------------------------------------------------------------
// Command and data enable delays, in clocks after the command state starts
// -----------------------------------------------------------------------------
`define LBC_NO_DLY        2'h0
`define LBC_RD_DLY_LONG     2'h1
`define LBC_WR_DLY_LONG     2'h2
`define LBC_XCV_WR_DLY_LONG 2'h1
`define LBC_ELAPSED_MAX   2'h3

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define LBC_STROBE_IDLE   5'h1F
`define LBC_DIR_RST       1'h1
`define LBC_GATE_RST      1'h0
`define LBC_STRAP_RST     1'h0

`endif

// ---- verilog/lbc_pkg.sv ----
// Types of the local bus command controller: bus states and cycle codes.
// Needs no include; the controller and the testbench import it.
package lbc_pkg;

   // -----------------------------------------------------------------------------
   // Bus states and decoded cycle types
   // -----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      LBC_IDLE   = 2'b00,
      LBC_STATUS = 2'b01,
      LBC_CMD    = 2'b10
   } lbc_bus_state_type;

   // Code is {memory_io_select, cycle_status_hi, cycle_status_lo}.
   typedef enum logic [2:0] {
      LBC_CYC_ACK    = 3'b000,
      LBC_CYC_IORD   = 3'b001,
      LBC_CYC_IOWR   = 3'b010,
      LBC_CYC_IDLE0  = 3'b011,
      LBC_CYC_HALT   = 3'b100,
      LBC_CYC_MEMRD  = 3'b101,
      LBC_CYC_MEMWR  = 3'b110,
      LBC_CYC_IDLE1  = 3'b111
   } lbc_cycle_type;

   // Strobe bit positions inside the command vector.
   typedef enum logic [2:0] {
      LBC_STB_ACK   = 3'b000,
      LBC_STB_IORD  = 3'b001,
      LBC_STB_IOWR  = 3'b010,
      LBC_STB_MEMRD = 3'b011,
      LBC_STB_MEMWR = 3'b100
   } lbc_strobe_type;

endpackage

// ---- verilog/lbc_top.sv ----
// Local bus command controller: decodes pipelined status into commands and
// transceiver controls. Assumes bus master, ready source and hold-off logic
// run on ref_clk_in; only the gate/grant pin is asynchronous.
`include "lbc_consts.svh"

// Overview of operation
// [R1] Decode select and status into cycle types.
// [R2] Low select means I/O space, high memory.
// [R3] Strap picks delayed or short command timing.
// [R4] Select latched at cycle start gates response.
// [R5] Hold-off high delays command, resampled each clock.
// [R6] Ready low ends cycle even without command.
// [R7] Ready source ends cycles; delayed mode waits.
// [R8] Ready held low during system reset.
// [R9] Gate/grant pin synchronised before use.
// [R10] Grant high floats strobes, drops transceiver enable.
// [R11] Short mode gate low forces outputs inactive.
// [R12] Address latch strobe for all but halt.
// [R13] Cascade enable only in interrupt acknowledge.
// [R14] Transceiver enable delayed for delayed-mode writes.
// [R15] Direction high for writes and idle.
// [R16] Direction changes only with transceivers disabled.
// [R17] Five active-low strobes, released by ready.
// [R18] Idle, status and command states, two clocks.
// [R19] Idle lasts as long as no cycle.
// [R20] Either status low starts a bus cycle; the code starts none for the halt code.
// [R21] Master asserts status in its phase one.
// [R22] Ready high at command end repeats state.
// [R23] Delayed mode: read plus one, write plus two.
// [R24] Address strobe in second half of status.
// [R25] Reset gives idle, inactive strobes, direction high.
module lbc_top (
   input  wire logic ref_clk_in,
   input  wire logic reset_n_in,
   input  wire logic cycle_status_hi_n_in,
   input  wire logic cycle_status_lo_n_in,
   input  wire logic memory_io_select_in,
   input  wire logic timing_mode_strap_in,
   input  wire logic latched_controller_select_in,
   input  wire logic command_hold_off_in,
   input  wire logic command_gate_or_grant_in,
   input  wire logic ready_n_in,
   output logic      intr_ack_strobe_n_out,
   output logic      io_read_strobe_n_out,
   output logic      io_write_strobe_n_out,
   output logic      mem_read_strobe_n_out,
   output logic      mem_write_strobe_n_out,
   output logic      command_oe_n_out,
   output logic      address_latch_strobe_out,
   output logic      cascade_address_enable_out,
   output logic      transceiver_enable_out,
   output logic      transfer_direction_out
);
   import lbc_pkg::*;

   // -----------------------------------------------------------------------------
   // Cycle type helpers
   // -----------------------------------------------------------------------------
   function automatic logic is_write(input lbc_cycle_type t);
      is_write = (t == LBC_CYC_IOWR) || (t == LBC_CYC_MEMWR);
   endfunction

   function automatic logic [4:0] strobe_sel(input lbc_cycle_type t);
      logic [4:0] v;
      v = 5'h00;
      case (t)
         LBC_CYC_ACK:   v[LBC_STB_ACK]   = 1'b1;
         LBC_CYC_IORD:  v[LBC_STB_IORD]  = 1'b1;
         LBC_CYC_IOWR:  v[LBC_STB_IOWR]  = 1'b1;
         LBC_CYC_MEMRD: v[LBC_STB_MEMRD] = 1'b1;
         LBC_CYC_MEMWR: v[LBC_STB_MEMWR] = 1'b1;
         default:       v = 5'h00;
      endcase
      strobe_sel = v;
   endfunction

   // -----------------------------------------------------------------------------
   // Reset release, strap capture and gate synchroniser
   // -----------------------------------------------------------------------------
   logic       rst_s1_ff;
   logic       rst_n;
   logic       long_mode_ff;
   logic       strap_taken_ff;
   logic [2:0] gate_sync_ff;
   logic       gate_ff;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_s1_ff <= 1'b0;
         rst_n     <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n     <= rst_s1_ff;
      end
   end

   // The strap is meant to stay static, so it is caught once after release.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         long_mode_ff   <= `LBC_STRAP_RST;
         strap_taken_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         long_mode_ff   <= timing_mode_strap_in; // [R3]
         strap_taken_ff <= 1'b1;
      end
   end

   // The pin may change at any time; a level counts once two stages agree.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         gate_sync_ff <= {3{`LBC_GATE_RST}};
         gate_ff      <= `LBC_GATE_RST;
      end else begin
         gate_sync_ff <= {gate_sync_ff[1:0], command_gate_or_grant_in}; // [R9]
         if (gate_sync_ff[1] == gate_sync_ff[2]) begin
            gate_ff <= gate_sync_ff[2];
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Status decode and bus state sequencing
   // -----------------------------------------------------------------------------
   lbc_bus_state_type state_ff;
   lbc_bus_state_type nxt_state;
   logic              phase_ff;
   logic              nxt_phase;
   lbc_cycle_type     type_ff;
   logic              sel_ff;
   logic [1:0]        elapsed_ff;
   logic              cmd_on_ff;
   logic [4:0]        cmd_n_ff;
   logic              oe_n_ff;
   logic              ale_ff;
   logic              casc_ff;
   logic              xcv_en_ff;
   logic              dtr_ff;

   // Status lines are active low; select low means I/O space.
   wire lbc_cycle_type cyc_code      = lbc_cycle_type'({memory_io_select_in,
                                        cycle_status_hi_n_in, cycle_status_lo_n_in}); // [R1] [R2]
   wire                status_active = !(cycle_status_hi_n_in && cycle_status_lo_n_in); // [R20]
   wire                cyc_end       = (state_ff == LBC_CMD) && phase_ff && !ready_n_in; // [R6]
   // A halt code starts nothing: no strobe, no latch strobe, inputs ignored.
   wire                can_start     = ((state_ff == LBC_IDLE) || cyc_end) && status_active
                                       && (cyc_code != LBC_CYC_HALT); // [R1] [R12]

   // The clock on which status is first seen is phase one of the status state,
   // so the state register enters it at its second phase.
   always_comb begin
      nxt_state = state_ff;
      nxt_phase = 1'b0;
      case (state_ff)
         LBC_IDLE: begin
            if (can_start) begin // [R19] [R20]
               nxt_state = LBC_STATUS;
               nxt_phase = 1'b1;
            end
         end
         LBC_STATUS: begin
            nxt_state = LBC_CMD; // [R18]
            nxt_phase = 1'b0;
         end
         LBC_CMD: begin
            if (!phase_ff) begin
               nxt_phase = 1'b1;
            end else if (ready_n_in) begin
               nxt_state = LBC_CMD; // [R22]
            end else if (can_start) begin
               nxt_state = LBC_STATUS; // [R22]
               nxt_phase = 1'b1;
            end else begin
               nxt_state = LBC_IDLE;
            end
         end
         default: begin
            nxt_state = LBC_IDLE;
            nxt_phase = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------------------------
   // Command, enable and direction decisions
   // -----------------------------------------------------------------------------
   wire lbc_cycle_type nxt_type    = can_start ? cyc_code : type_ff;
   wire                nxt_sel     = can_start ? latched_controller_select_in : sel_ff; // [R4]
   wire                to_cmd      = (nxt_state == LBC_CMD);
   wire                type_wr     = is_write(type_ff);
   wire [1:0]          nxt_elapsed = (state_ff != LBC_CMD) ? `LBC_NO_DLY :
                                     (elapsed_ff == `LBC_ELAPSED_MAX) ? elapsed_ff :
                                     elapsed_ff + 2'h1;
   wire [1:0]          cmd_dly     = !long_mode_ff ? `LBC_NO_DLY :
                                     type_wr ? `LBC_WR_DLY_LONG : `LBC_RD_DLY_LONG; // [R23]
   wire [1:0]          xcv_dly     = (long_mode_ff && type_wr) ? `LBC_XCV_WR_DLY_LONG :
                                     `LBC_NO_DLY; // [R14] [R23]
   // Grant is active low in delayed mode, gate active high in short mode.
   wire                gate_ok     = long_mode_ff ? !gate_ff : gate_ff; // [R10] [R11]
   wire                nxt_cmd_on  = to_cmd && sel_ff && (nxt_elapsed >= cmd_dly)
                                     && (cmd_on_ff || !command_hold_off_in); // [R5]
   wire [4:0]          nxt_cmd_n   = ~(strobe_sel(type_ff) & {5{nxt_cmd_on && gate_ok}}); // [R17]
   wire                nxt_oe_n    = long_mode_ff && gate_ff; // [R10]
   wire                dir_target  = (nxt_state != LBC_IDLE) ? is_write(nxt_type)
                                     : `LBC_DIR_RST; // [R15]
   // Direction waits while the transceivers are on, and the enable waits
   // until the direction matches, so the two never switch together.
   wire                nxt_dtr     = xcv_en_ff ? dtr_ff : dir_target; // [R16]
   wire                nxt_xcv_en  = to_cmd && sel_ff && gate_ok && (nxt_elapsed >= xcv_dly)
                                     && (dtr_ff == type_wr); // [R14] [R16]
   wire                nxt_ale     = (nxt_state == LBC_STATUS); // [R12] [R24]
   wire                nxt_casc    = (nxt_ale && (nxt_type == LBC_CYC_ACK)) ||
                                     ((state_ff == LBC_STATUS) && (type_ff == LBC_CYC_ACK)); // [R13]

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= LBC_IDLE; // [R25]
         phase_ff   <= 1'b0;
         type_ff    <= LBC_CYC_IDLE1;
         sel_ff     <= 1'b0;
         elapsed_ff <= `LBC_NO_DLY;
         cmd_on_ff  <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         phase_ff   <= nxt_phase;
         type_ff    <= nxt_type;
         sel_ff     <= nxt_sel;
         elapsed_ff <= nxt_elapsed;
         cmd_on_ff  <= nxt_cmd_on;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         oe_n_ff <= 1'b0; // [R25]
         ale_ff  <= 1'b0;
         casc_ff   <= 1'b0;
         xcv_en_ff <= 1'b0;
         dtr_ff  <= `LBC_DIR_RST;
      end else begin
         oe_n_ff <= nxt_oe_n;
         ale_ff  <= nxt_ale;
         casc_ff   <= nxt_casc;
         xcv_en_ff <= nxt_xcv_en;
         dtr_ff  <= nxt_dtr;
      end
   end

   for (genvar i = 0; i < 5; i++) begin : g_strobe
      always_ff @(posedge ref_clk_in or negedge rst_n) begin
         if (!rst_n) begin
            cmd_n_ff[i] <= 1'b1; // [R25]
         end else begin
            cmd_n_ff[i] <= nxt_cmd_n[i];
         end
      end
   end

   assign intr_ack_strobe_n_out      = cmd_n_ff[LBC_STB_ACK];
   assign io_read_strobe_n_out       = cmd_n_ff[LBC_STB_IORD];
   assign io_write_strobe_n_out      = cmd_n_ff[LBC_STB_IOWR];
   assign mem_read_strobe_n_out      = cmd_n_ff[LBC_STB_MEMRD];
   assign mem_write_strobe_n_out     = cmd_n_ff[LBC_STB_MEMWR];
   assign command_oe_n_out           = oe_n_ff;
   assign address_latch_strobe_out   = ale_ff;
   assign cascade_address_enable_out = casc_ff;
   assign transceiver_enable_out     = xcv_en_ff;
   assign transfer_direction_out     = dtr_ff;

   // -----------------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------------
   a_ale_not_halt: assert property ( // [R12] [R24]
      @(posedge ref_clk_in) disable iff (!rst_n)
      ale_ff |-> (state_ff == LBC_STATUS) && (type_ff != LBC_CYC_HALT) ##1 !ale_ff)
      else $error("address latch strobe outside status state");
   a_casc_ack_only: assert property ( // [R13]
      @(posedge ref_clk_in) disable iff (!rst_n)
      casc_ff |-> (type_ff == LBC_CYC_ACK))
      else $error("cascade enable outside interrupt acknowledge");
   a_dir_quiet_den: assert property ( // [R16]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (dtr_ff != $past(dtr_ff)) |-> !xcv_en_ff && !$past(xcv_en_ff))
      else $error("direction changed with transceivers enabled");
   a_dir_idle_high: assert property ( // [R15]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (state_ff == LBC_IDLE) [*3] |-> dtr_ff)
      else $error("direction low while idle");
   a_ready_release: assert property ( // [R17] [R6]
      @(posedge ref_clk_in) disable iff (!rst_n)
      cyc_end |=> (cmd_n_ff == `LBC_STROBE_IDLE) && (state_ff != LBC_CMD))
      else $error("strobe or command state held after ready");
   a_wait_repeat: assert property ( // [R22]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (state_ff == LBC_CMD && phase_ff && ready_n_in) |=>
         (state_ff == LBC_CMD) && !phase_ff && $stable(type_ff) && $stable(dtr_ff))
      else $error("wait state not repeated");
   a_short_read: assert property ( // [R23] [R5]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (state_ff == LBC_STATUS && !long_mode_ff && sel_ff && gate_ff && !command_hold_off_in
       && !type_wr) |=> !(&cmd_n_ff))
      else $error("short mode read command late");
   a_long_write_delay: assert property ( // [R23]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (state_ff == LBC_STATUS && long_mode_ff && type_wr) |=> (&cmd_n_ff) [*2])
      else $error("delayed mode write command early");
   a_hold_off: assert property ( // [R5]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (command_hold_off_in && !cmd_on_ff) |=> !cmd_on_ff)
      else $error("command started during hold-off");
   a_grant_float: assert property ( // [R10]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (long_mode_ff && gate_ff) |=> oe_n_ff && !xcv_en_ff && (&cmd_n_ff))
      else $error("strobes driven without grant");
   a_gate_low: assert property ( // [R11]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (!long_mode_ff && !gate_ff) |=> !oe_n_ff && !xcv_en_ff && (&cmd_n_ff))
      else $error("strobes active with gate low");
   a_unselected: assert property ( // [R4]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (state_ff == LBC_CMD && !sel_ff) |-> (&cmd_n_ff) && !xcv_en_ff)
      else $error("response to unselected cycle");

endmodule

// ---- dv/lbc_master_model.sv ----
// Behavioural local bus master that drives the status lines and the select line.
// Assumes requests arrive by non-blocking assignment at the falling clock edge.
module lbc_master_model (
   input  wire logic       clk_in,
   input  wire logic       req_in,
   input  wire logic [2:0] code_in,
   output logic            status_hi_n_out,
   output logic            status_lo_n_out,
   output logic            mem_io_sel_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] left_ff  = 2'h0;
   logic [2:0] code_ff  = 3'h7;
   logic       pend_ff  = 1'b0;
   logic       phase_ff = 1'b0;
   logic       busy;

   // ----------
   // Status launch
   // ----------
   // The master's own clock runs at half rate; status only starts in its first phase.
   always @(negedge clk_in) begin
      phase_ff <= ~phase_ff;
      if (left_ff != 2'h0) begin
         left_ff <= left_ff - 2'h1;
      end else if ((pend_ff || req_in) && !phase_ff) begin
         left_ff <= 2'h2;
         code_ff <= code_in;
         pend_ff <= 1'b0;
      end else if (req_in) begin
         pend_ff <= 1'b1;
      end
   end

   assign busy = (left_ff != 2'h0);
   // Status lines have pull-ups; the select line has none, so it shows the inverse when free.
   assign status_hi_n_out = busy ? code_ff[1] : 1'b1;
   assign status_lo_n_out = busy ? code_ff[0] : 1'b1;
   assign mem_io_sel_out  = busy ? code_ff[2] : ~code_ff[2];
endmodule

// ---- dv/local_bus_command_controller_tb.sv ----
// Self-checking bench of the local bus command controller, with random cycles.
// Assumes the master model beside it and the constants header in the include path.
`include "lbc_consts.svh"
module local_bus_command_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lbc_pkg::*;

   logic       ref_clk = 1'b0;
   logic       reset_n, req, csel, hold, gate, ready_n, strap;
   logic [2:0] code;
   wire logic  st_hi_n, st_lo_n, mio;
   wire logic [4:0] stb;
   wire logic  oe_n, ale, casc, xcv, dir;
   int         fail_count = 0;
   int         num_checks = 0;

   always #25 ref_clk = ~ref_clk;

   lbc_master_model i_master (.clk_in(ref_clk), .req_in(req), .code_in(code),
      .status_hi_n_out(st_hi_n), .status_lo_n_out(st_lo_n), .mem_io_sel_out(mio));

   lbc_top i_dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .cycle_status_hi_n_in(st_hi_n),
      .cycle_status_lo_n_in(st_lo_n), .memory_io_select_in(mio), .timing_mode_strap_in(strap),
      .latched_controller_select_in(csel), .command_hold_off_in(hold),
      .command_gate_or_grant_in(gate), .ready_n_in(ready_n),
      .intr_ack_strobe_n_out(stb[0]), .io_read_strobe_n_out(stb[1]),
      .io_write_strobe_n_out(stb[2]), .mem_read_strobe_n_out(stb[3]),
      .mem_write_strobe_n_out(stb[4]), .command_oe_n_out(oe_n),
      .address_latch_strobe_out(ale), .cascade_address_enable_out(casc),
      .transceiver_enable_out(xcv), .transfer_direction_out(dir));

   // ----------
   // Compare and verdict
   // ----------
   task automatic chk_bit(input logic exp, input logic act);
      num_checks++;
      if (act !== exp) begin
         fail_count++;
         $display("BAD t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask

   task automatic chk_vec(input logic [4:0] exp, input logic [4:0] act);
      num_checks++;
      if (act !== exp) begin
         fail_count++;
         $display("BAD t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask

   task automatic chk_num(input int exp, input int act);
      num_checks++;
      if (act != exp) begin
         fail_count++;
         $display("BAD t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask

   task automatic tally_and_finish();
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------
   // Expectations
   // ----------
   function automatic logic is_wr(input logic [2:0] c);
      return (c == LBC_CYC_IOWR || c == LBC_CYC_MEMWR);
   endfunction

   function automatic int cmd_dly(input logic lm, input logic [2:0] c);
      if (!lm) return int'(`LBC_NO_DLY);
      return is_wr(c) ? int'(`LBC_WR_DLY_LONG) : int'(`LBC_RD_DLY_LONG);
   endfunction

   function automatic logic [4:0] exp_stb(input logic [2:0] c);
      int idx;
      idx = (c == LBC_CYC_ACK) ? 0 : (c == LBC_CYC_IORD) ? 1 : (c == LBC_CYC_IOWR) ? 2 :
            (c == LBC_CYC_MEMRD) ? 3 : 4;
      return 5'h1F ^ (5'h01 << idx);
   endfunction

   // ----------
   // Bus cycle driver and monitor
   // ----------
   task automatic do_reset(input logic lm);
      reset_n <= 1'b0;
      ready_n <= 1'b0;
      strap   <= lm;
      repeat (10) @(negedge ref_clk);
      chk_vec(5'h1F, stb);
      chk_bit(1'b0, ale);
      chk_bit(1'b0, casc);
      chk_bit(1'b0, xcv);
      chk_bit(1'b0, oe_n);
      chk_bit(1'b1, dir);
      reset_n <= 1'b1;
      repeat (6) @(negedge ref_clk);
   endtask

   task automatic run_cycle(input logic [2:0] c, input logic sel, input int h, input int w);
      int a, s, e, d, n_casc, n_ale, dl;
      logic dmin, pd, pdir, en;
      logic [4:0] sv;
      a = -1; s = -1; e = -1; d = -1; n_casc = 0; n_ale = 0; dmin = 1'b1;
      dl = cmd_dly(strap, c);
      code <= c; csel <= sel; ready_n <= 1'b1; req <= 1'b1;
      @(negedge ref_clk);
      req <= 1'b0;
      pd = xcv; pdir = dir;
      for (int i = 0; i < 24; i++) begin
         @(negedge ref_clk);
         if (ale === 1'b1) begin
            n_ale++;
            if (a < 0) a = i;
         end
         if (casc === 1'b1) n_casc++;
         if (stb !== 5'h1F && s < 0) begin
            s = i;
            sv = stb;
         end
         if (stb === 5'h1F && s >= 0 && e < 0) e = i;
         if (xcv === 1'b1 && d < 0) d = i;
         if (dir === 1'b0) dmin = 1'b0;
         if (dir !== pdir) chk_bit(1'b0, pd | xcv);
         pd = xcv; pdir = dir;
         hold    <= (a >= 0 && i >= a + dl && i < a + dl + h);
         ready_n <= !(a >= 0 && i >= a + 2 + 2 * w);
      end
      if (c[1:0] == 2'b11 || c == LBC_CYC_HALT) begin
         chk_num(0, n_ale + n_casc);
         chk_num(-1, s + d + 1);
         return;
      end
      chk_num(1, n_ale);
      chk_num((c == LBC_CYC_ACK) ? 2 : 0, n_casc);
      chk_bit(is_wr(c), dmin);
      chk_bit(1'b1, dir);
      chk_bit(1'b0, xcv);
      en = sel && (strap ? !gate : gate);
      chk_bit(strap & gate, oe_n);
      if (!en) begin
         chk_num(-1, s);
         chk_num(-1, d);
         return;
      end
      if (a + 1 + dl + h > a + 2 + 2 * w) begin
         chk_num(-1, s);
         return;
      end
      chk_num(a + 1 + dl + h, s);
      chk_vec(exp_stb(c), sv);
      chk_num(a + 3 + 2 * w, e);
      if (h == 0) chk_num(a + 1 + ((strap && is_wr(c)) ? 1 : 0), d);
   endtask

   // ----------
   // Main sequence
   // ----------
   initial begin
      int rc, rh, rw;
      reset_n = 1'b0; req = 1'b0; code = 3'h7; csel = 1'b1; hold = 1'b0;
      gate = 1'b0; ready_n = 1'b0; strap = 1'b0;
      void'($urandom(44));
      for (int m = 0; m < 2; m++) begin
         do_reset(m[0]);
         // The gate pin is asynchronous, so each change is given time to pass the synchroniser.
         gate <= !m[0];
         repeat (4) @(negedge ref_clk);
         for (int c = 0; c < 8; c++) run_cycle(c[2:0], 1'b1, 0, m);
         run_cycle(LBC_CYC_MEMRD, 1'b0, 0, 1);
         run_cycle(LBC_CYC_IORD, 1'b1, 3, 2);
         run_cycle(LBC_CYC_MEMWR, 1'b1, 8, 1);
         gate <= m[0];
         repeat (4) @(negedge ref_clk);
         run_cycle(LBC_CYC_IOWR, 1'b1, 0, 1);
         gate <= !m[0];
         repeat (4) @(negedge ref_clk);
         for (int k = 0; k < 20; k++) begin
            rc = $urandom_range(7, 0);
            rh = $urandom_range(2, 0);
            rw = m + rh + $urandom_range(1, 0);
            run_cycle(rc[2:0], $urandom_range(9, 0) != 0, rh, rw);
         end
      end
      tally_and_finish();
   end

   initial begin
      #(50 * 10000);
      fail_count++;
      tally_and_finish();
   end
endmodule
